// [common/fifo_flag_cfg.svh]
// constants for the flag-and-wrap fifo controller
// assumes inclusion by bare name from the design files
`ifndef FIFO_FLAG_CFG_SVH
`define FIFO_FLAG_CFG_SVH
`define FF_DATA_W      9
`define FF_ADDR_W      9
`define FF_THR_W       10
`define FF_STATIC_AF   10'h1f0
`define FF_STATIC_AE   10'h010
`define FF_DYN_AF_RST  10'h1f0
`define FF_DYN_AE_RST  10'h010
`define FF_SYNC_STAGES 3
`endif

// [common/fifo_flag_pkg.sv]
// types shared by the flag-and-wrap fifo controller
// assumes no other package
package fifo_flag_pkg;
   // flag configuration, one-hot
   typedef enum logic [2:0] {
      FLAG_NONE    = 3'h1,
      FLAG_STATIC  = 3'h2,
      FLAG_DYNAMIC = 3'h4
   } flag_mode_e;
endpackage : fifo_flag_pkg

// [hdl/bit_sync3.sv]
// three-stage synchroniser with agreement filter for one pin level
// assumes clk is the controller clock; input is asynchronous
`timescale 1ns/10ps
`include "fifo_flag_cfg.svh"
module bit_sync3 (
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ce,
   // level
   input  wire logic din,
   output logic      dout
);
   logic [2:0] s_q, s_d;  // sync chain
   logic       o_q, o_d;  // filtered level

   // next values: change counts once stages two and three agree
   always_comb begin
      s_d = {s_q[1:0], din};
      o_d = (s_q[1] == s_q[2]) ? s_q[2] : o_q;
   end

   // registers only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= 3'h0;
         o_q <= 1'b0;
      end else if (ce) begin
         s_q <= s_d;
         o_q <= o_d;
      end
   end

   assign dout = o_q;
endmodule : bit_sync3

// [hdl/fifo_flag_wrap_control.sv]
// fifo controller with selectable flag modes and counter wrap options
// assumes one clock; write and read requests come from logic on clk;
// the jtag reload strobe arrives from another domain and is synchronised
`timescale 1ns/10ps
`include "fifo_flag_cfg.svh"

// What this block does
// [R1] write-wrap option: write counter rolls, keeps storing
// [R2] read-wrap option: read counter rolls, rereads data
// [R3] flag modes: none, fixed, or run-time settable
// [R4] fixed thresholds come from build-time constants
// [R5] run-time thresholds reloadable by user or jtag
// [R6] full follows physical depth, not requested depth
// [R7] shared clock or separate clocks selectable; this build has one shared clk only
// [R8] read and write widths must match
// [R9] cascades limited to 64 ram blocks
// [R10] no wrap: ignore full writes, empty reads
module fifo_flag_wrap_control
   import fifo_flag_pkg::*;
#(
   parameter int DATA_W = `FF_DATA_W,
   parameter int ADDR_W = `FF_ADDR_W
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              ce,
   // configuration
   input  wire flag_mode_e        flag_mode,
   input  wire logic              wrap_write,
   input  wire logic              wrap_read,
   // dynamic threshold reload from user logic
   input  wire logic              thr_load,
   input  wire logic [`FF_THR_W-1:0] thr_af_in,
   input  wire logic [`FF_THR_W-1:0] thr_ae_in,
   // dynamic threshold reload from the user jtag port
   input  wire logic              user_jtag_port_load,
   input  wire logic [`FF_THR_W-1:0] user_jtag_port_af,
   input  wire logic [`FF_THR_W-1:0] user_jtag_port_ae,
   // write side
   input  wire logic              wr_en,
   input  wire logic [DATA_W-1:0] wr_data,
   // read side
   input  wire logic              rd_en,
   output logic [DATA_W-1:0]      rd_data,
   output logic                   rd_valid,
   // status
   output logic                   full,
   output logic                   empty,
   output logic                   almost_full,
   output logic                   almost_empty,
   output logic                   wr_ignored,
   output logic                   rd_ignored
);
   // [R7] single clock build: one clk serves both ports here
   localparam int DEPTH = 1 << ADDR_W;   // physical depth
   localparam int CW    = ADDR_W + 1;

   ////////////////////////////////////////////////////////////////////
   // storage
   logic [DATA_W-1:0] mem [DEPTH];       // physical ram array

   ////////////////////////////////////////////////////////////////////
   // jtag reload strobe crossing
   logic jl_sync;                        // filtered jtag load level
   logic jl_prev_q, jl_prev_d;           // for rising edge
   logic jl_pulse;

   bit_sync3 u_jl_sync (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .din    (user_jtag_port_load),
      .dout   (jl_sync)
   );
   // jtag data is held stable by the shifter across the update
   assign jl_pulse  = jl_sync & ~jl_prev_q;
   assign jl_prev_d = jl_sync;

   ////////////////////////////////////////////////////////////////////
   // pointers and count
   logic [ADDR_W-1:0] wp_q, wp_d;        // write pointer
   logic [ADDR_W-1:0] rp_q, rp_d;        // read pointer
   logic [CW-1:0]     cnt_q, cnt_d;      // fill count
   logic [DATA_W-1:0] rd_q, rd_d;        // read data register
   logic              rv_q, rv_d;        // read data valid
   logic              wi_q, wi_d;        // write ignored pulse
   logic              ri_q, ri_d;        // read ignored pulse
   logic              do_wr, do_rd;
   logic              is_full, is_empty;

   // [R6] full is judged against the whole physical array
   assign is_full  = (cnt_q == CW'(DEPTH));
   assign is_empty = (cnt_q == '0);

   // next values of pointers, count and read port
   always_comb begin
      // [R1] wrap lets writes proceed even when full
      // [R10] otherwise writes at full are dropped
      do_wr = wr_en & (~is_full | wrap_write);
      // [R2] wrap lets reads proceed when empty, rereading old words
      // [R10] otherwise reads at empty are dropped
      do_rd = rd_en & (~is_empty | wrap_read);
      wp_d  = wp_q;
      rp_d  = rp_q;
      cnt_d = cnt_q;
      rd_d  = rd_q;
      rv_d  = do_rd;
      wi_d  = wr_en & ~do_wr;            // [R10]
      ri_d  = rd_en & ~do_rd;            // [R10]
      if (do_wr) begin
         wp_d = wp_q + 1'b1;             // [R1] natural roll at end
      end
      if (do_rd) begin
         rp_d = rp_q + 1'b1;             // [R2] natural roll at end
         rd_d = mem[rp_q];
      end
      // count saturates: wrapped accesses never leave the legal range
      if (do_wr && !do_rd && !is_full) begin
         cnt_d = cnt_q + 1'b1;
      end else if (do_rd && !do_wr && !is_empty) begin
         cnt_d = cnt_q - 1'b1;
      end else begin
         cnt_d = cnt_q;
      end
   end

   // pointer registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wp_q      <= '0;
         rp_q      <= '0;
         cnt_q     <= '0;
         rd_q      <= '0;
         rv_q      <= 1'b0;
         wi_q      <= 1'b0;
         ri_q      <= 1'b0;
         jl_prev_q <= 1'b0;
      end else if (ce) begin
         wp_q      <= wp_d;
         rp_q      <= rp_d;
         cnt_q     <= cnt_d;
         rd_q      <= rd_d;
         rv_q      <= rv_d;
         wi_q      <= wi_d;
         ri_q      <= ri_d;
         jl_prev_q <= jl_prev_d;
      end
   end

   // ram write, no reset: contents are undefined until written
   always_ff @(posedge clk) begin
      if (ce && do_wr) begin
         mem[wp_q] <= wr_data;           // [R1]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // threshold registers
   logic [`FF_THR_W-1:0] af_q, af_d;     // dynamic almost-full level
   logic [`FF_THR_W-1:0] ae_q, ae_d;     // dynamic almost-empty level

   // next thresholds: user load wins over a jtag load in the same cycle
   always_comb begin
      af_d = af_q;
      ae_d = ae_q;
      if (thr_load) begin
         af_d = thr_af_in;               // [R5]
         ae_d = thr_ae_in;
      end else if (jl_pulse) begin
         af_d = user_jtag_port_af;       // [R5]
         ae_d = user_jtag_port_ae;
      end
   end

   // threshold registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         af_q <= `FF_DYN_AF_RST;
         ae_q <= `FF_DYN_AE_RST;
      end else if (ce) begin
         af_q <= af_d;
         ae_q <= ae_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flag generation
   logic [`FF_THR_W-1:0] cnt_ext;
   logic af_flag_d, ae_flag_d;           // next flag values
   logic af_flag_q, ae_flag_q;           // registered flags

   assign cnt_ext = `FF_THR_W'(cnt_q);

   // select threshold source by flag mode
   always_comb begin
      case (flag_mode)
         FLAG_NONE: begin                // [R3] flags held low
            af_flag_d = 1'b0;
            ae_flag_d = 1'b0;
         end
         FLAG_STATIC: begin              // [R3] [R4] fixed at build
            af_flag_d = (cnt_ext >= `FF_STATIC_AF);
            ae_flag_d = (cnt_ext <= `FF_STATIC_AE);
         end
         FLAG_DYNAMIC: begin             // [R3] [R5] register levels
            af_flag_d = (cnt_ext >= af_q);
            ae_flag_d = (cnt_ext <= ae_q);
         end
         default: begin
            af_flag_d = 1'b0;
            ae_flag_d = 1'b0;
         end
      endcase
   end

   // flag registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         af_flag_q <= 1'b0;
         ae_flag_q <= 1'b0;
      end else if (ce) begin
         af_flag_q <= af_flag_d;
         ae_flag_q <= ae_flag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign rd_data      = rd_q;
   assign rd_valid     = rv_q;
   assign full         = is_full;        // [R6]
   assign empty        = is_empty;
   assign almost_full  = af_flag_q;
   assign almost_empty = ae_flag_q;
   assign wr_ignored   = wi_q;
   assign rd_ignored   = ri_q;
endmodule : fifo_flag_wrap_control

// [verification/fifo_flag_sva.sv]
// port assertions for the flag-and-wrap fifo controller
// assumes a bind onto fifo_flag_wrap_control, one clock
`timescale 1ns/10ps
module fifo_flag_sva
   import fifo_flag_pkg::*;
(
   // clock, reset and enable
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       ce,
   // configuration
   input wire flag_mode_e flag_mode,
   input wire logic       wrap_write,
   input wire logic       wrap_read,
   // requests
   input wire logic       wr_en,
   input wire logic       rd_en,
   // status
   input wire logic       full,
   input wire logic       empty,
   input wire logic       rd_valid,
   input wire logic       wr_ignored,
   input wire logic       rd_ignored,
   input wire logic       almost_full,
   input wire logic       almost_empty
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic rd_ok;   // read that must be answered
   logic wr_full; // lone write at full
   assign rd_ok   = ce && rd_en && (!empty || wrap_read);
   assign wr_full = ce && wr_en && !rd_en && full;
   rd_answer_a: assert property (rd_ok |=> rd_valid)
      else $error("read not answered");
   rd_refuse_a: assert property (ce && rd_en && empty && !wrap_read
      |=> rd_ignored && !rd_valid) else $error("empty read taken");
   wr_refuse_a: assert property (wr_full && !wrap_write
      |=> wr_ignored && full) else $error("full write taken");
   wr_wrap_a: assert property (wr_full && wrap_write
      |=> full && !wr_ignored) else $error("wrapped write refused");
   rd_wrap_a: assert property (rd_ok && empty && !wr_en
      |=> empty && !rd_ignored) else $error("wrapped read refused");
   full_excl_a: assert property (!(full && empty))
      else $error("full and empty together");
   wr_take_a: assert property (ce && wr_en && !rd_en && empty
      |=> !empty) else $error("write to empty lost");
   none_flags_a: assert property (flag_mode == FLAG_NONE
      && $past(flag_mode) == FLAG_NONE |-> !almost_full && !almost_empty)
      else $error("flag raised with no flags");
   st_empty_a: assert property ((flag_mode == FLAG_STATIC && empty)[*3]
      |-> almost_empty) else $error("static almost empty missing");
   st_full_a: assert property ((flag_mode == FLAG_STATIC && full)[*3]
      |-> almost_full) else $error("static almost full missing");
endmodule : fifo_flag_sva

// [verification/fifo_user_model.sv]
// user logic on the write and read sides of the fifo
// assumes the same clock as the controller
`timescale 1ns/10ps
`include "fifo_flag_cfg.svh"
module fifo_user_model (
   // clock
   input  wire logic             clk,
   // one physical block only, well inside the cascade limit
   // requests, same width both sides
   output logic                  wr_en,
   output logic [`FF_DATA_W-1:0] wr_data,
   output logic                  rd_en
);
   initial begin
      {wr_en, rd_en, wr_data} = 11'h000;
   end
   // one word per request, held for one taken edge; idle data
   // inverted so a stale word cannot pass for a new one
   task automatic xfer(input logic w, r, input logic [8:0] d);
      @(posedge clk);
      #1 {wr_en, rd_en, wr_data} = {w, r, d};
      @(posedge clk);
      #1 {wr_en, rd_en, wr_data} = {2'h0, ~d};
   endtask : xfer
endmodule : fifo_user_model

// [verification/fifo_flag_wrap_control_tb.sv]
// self-checking bench for the flag-and-wrap fifo controller
// assumes the user model drives both fifo sides
`timescale 1ns/10ps
`include "fifo_flag_cfg.svh"
module fifo_flag_wrap_control_tb
   import fifo_flag_pkg::*;
;
   logic clk = 0; // one shared clock
   logic resetn, ce, wrap_write, wrap_read, thr_load, wr_en, rd_en;
   logic user_jtag_port_load, rd_valid, full, empty;
   logic almost_full, almost_empty, wr_ignored, rd_ignored;
   logic [`FF_THR_W-1:0] thr_af_in, thr_ae_in;
   logic [`FF_THR_W-1:0] user_jtag_port_af, user_jtag_port_ae;
   logic [`FF_DATA_W-1:0] wr_data, rd_data;
   flag_mode_e flag_mode;
   int n_errors = 0, n_compared = 0, cyc = 0, i;
   always #4 clk = ~clk;
   fifo_flag_wrap_control u_dut (.clk, .resetn, .ce, .flag_mode,
      .wrap_write, .wrap_read, .thr_load, .thr_af_in, .thr_ae_in,
      .user_jtag_port_load, .user_jtag_port_af, .user_jtag_port_ae,
      .wr_en, .wr_data, .rd_en, .rd_data, .rd_valid, .full, .empty,
      .almost_full, .almost_empty, .wr_ignored, .rd_ignored);
   fifo_user_model u_user (.clk, .wr_en, .wr_data, .rd_en);
   task automatic chk(input string nm, input logic [9:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_n
   task automatic rst();
      resetn = 0;
      wait_n(4);
      resetn = 1;
   endtask : rst
   task automatic load(); // one-cycle user threshold load
      thr_load = 1;
      wait_n(1);
      thr_load = 0;
   endtask : load
   task automatic fill();
      for (i = 0; i < 512; i++) begin
         u_user.xfer(1, 0, i[8:0]);
         if (i == 4) chk("almost_full", almost_full, 0);
         if (i == 510) chk("full", full, 0);
      end
   endtask : fill
   // hang guard: the full run needs under 8000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      {ce, resetn, wrap_write, wrap_read, thr_load} = 5'h10;
      user_jtag_port_load = 1'h0;
      flag_mode = FLAG_STATIC;
      // user and jtag levels differ so each load shows on the flags
      {thr_af_in, thr_ae_in} = {10'h002, 10'h001};
      {user_jtag_port_af, user_jtag_port_ae} = {10'h004, 10'h003};
      rst();
      chk("empty", empty, 1);
      load();
      fill();
      chk("full", full, 1);
      u_user.xfer(1, 0, 9'h155);
      chk("wr_ignored", wr_ignored, 1);
      for (i = 0; i < 512; i++) begin
         u_user.xfer(0, 1, 0);
         chk("rd_data", rd_data, i[8:0]);
         chk("rd_valid", rd_valid, 1);
      end
      u_user.xfer(0, 1, 0);
      chk("rd_ignored", rd_ignored, 1);
      chk("rd_valid", rd_valid, 0);
      wrap_read = 1;
      for (i = 0; i < 2; i++) begin
         u_user.xfer(0, 1, 0);
         chk("rd_data", rd_data, i[8:0]);
      end
      {wrap_read, wrap_write} = 2'h1;
      rst();
      fill();
      u_user.xfer(1, 0, 9'h1aa);
      u_user.xfer(1, 0, 9'h1ab);
      chk("full", full, 1);
      for (i = 0; i < 3; i++) begin
         u_user.xfer(0, 1, 0);
         chk("rd_data", rd_data, (i == 2) ? 10'h002 : 10'(9'h1aa + i));
      end
      wrap_write = 1'h0;
      flag_mode = FLAG_DYNAMIC;
      rst();
      // clock enable low: the write must not be taken
      ce = 1'h0;
      u_user.xfer(1, 0, 9'h033);
      chk("empty", empty, 1);
      ce = 1'h1;
      u_user.xfer(1, 0, 9'h011);
      u_user.xfer(1, 0, 9'h022);
      wait_n(3);
      chk("almost_full", almost_full, 0);
      chk("almost_empty", almost_empty, 1);
      load();
      wait_n(3);
      chk("almost_full", almost_full, 1);
      chk("almost_empty", almost_empty, 0);
      flag_mode = FLAG_NONE;
      wait_n(3);
      chk("almost_full", almost_full, 0);
      flag_mode = FLAG_DYNAMIC;
      user_jtag_port_load = 1'h1;
      wait_n(8);
      chk("almost_full", almost_full, 0);
      chk("almost_empty", almost_empty, 1);
      test_done();
   end
endmodule : fifo_flag_wrap_control_tb
bind fifo_flag_wrap_control fifo_flag_sva u_sva (.clk, .resetn, .ce,
   .flag_mode, .wrap_write, .wrap_read, .wr_en, .rd_en, .full, .empty,
   .rd_valid, .wr_ignored, .rd_ignored, .almost_full, .almost_empty);
